/* File: rtl/status_groups_pkg.sv */
// Purpose: shared constants and carriers for the trigger and measurement status groups
// Assumes: one 20 MHz clock, asynchronous active-high reset
// Notes: the command port stands for the decoded status commands of the host language
package status_groups_pkg;

	// ==========================================================
	// widths and reset values
	localparam int STATUS_WIDTH = 16;
	localparam logic [15:0] RISE_FILTER_RESET = 16'hFFFF;
	localparam logic [15:0] FALL_FILTER_RESET = 16'h0000;
	localparam logic [15:0] EVENT_MASK_RESET = 16'h0000;
	localparam logic [15:0] EVENTS_RESET = 16'h0000;
	localparam logic [15:0] READ_DATA_RESET = 16'h0000;

	// ==========================================================
	// bit positions
	localparam int TRIGGER_LAYER_BIT = 1;
	localparam int BUFFER_FULL_BIT = 9;
	localparam int OPER_WAIT_TRIGGER_BIT = 5;
	localparam logic [15:0] TRIGGER_MASK_WRITABLE = 16'h0002;

	// ==========================================================
	// group indices
	localparam int GROUP_COUNT = 2;
	localparam logic GROUP_TRIGGER = 1'h0;
	localparam logic GROUP_MEASURE = 1'h1;

	// ==========================================================
	// command encodings
	typedef enum logic [1:0] {
		op_write,
		op_read,
		op_preset,
		op_clear_status
	} cmd_op_e;

	typedef enum logic [2:0] {
		reg_live_state,
		reg_rise_filter,
		reg_fall_filter,
		reg_latched_events,
		reg_event_mask
	} reg_sel_e;

	typedef struct packed {
		logic valid;
		cmd_op_e op;
		logic group;
		reg_sel_e sel;
		logic [15:0] data;
	} command_s;

	typedef struct packed {
		logic valid;
		logic error;
		logic [15:0] data;
	} response_s;

endpackage : status_groups_pkg

/* File: rtl/status_group.sv */
// Purpose: one status group: transition filter, latched events and masked summary
// Assumes: condition bits synchronous to sys_clk
// Notes: first cycle after reset only primes the history, so no false edge is seen
module status_group #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] live_state,
	input wire logic [WIDTH-1:0] rising_edge_filter,
	input wire logic [WIDTH-1:0] falling_edge_filter,
	input wire logic [WIDTH-1:0] event_mask,
	input wire logic clear_events,
	output logic [WIDTH-1:0] latched_events,
	output logic summary
);

	if (WIDTH < 1) begin : gen_width_check
		$error("status_group: WIDTH must be at least 1");
	end

	typedef struct packed {
		logic primed;
		logic [WIDTH-1:0] prev;
		logic [WIDTH-1:0] events;
	} group_state_s;

	group_state_s state;
	group_state_s next_state;
	logic [WIDTH-1:0] rose;
	logic [WIDTH-1:0] fell;

	// ==========================================================
	// edge detection and latching
	always_comb begin
		next_state = state;
		rose = live_state & ~state.prev; // see (R19)
		fell = ~live_state & state.prev; // see (R19)
		if (!state.primed) begin
			rose = '0;
			fell = '0;
		end
		next_state.primed = 1'b1;
		next_state.prev = live_state;
		if (clear_events) begin
			next_state.events = '0; // see (R11)
		end
		// a fresh qualified edge beats a same-cycle clear
		next_state.events = next_state.events // see (R10) (R18)
			| (rose & rising_edge_filter) // see (R5) (R7)
			| (fell & falling_edge_filter); // see (R6) (R7)
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= '0; // see (R12)
		end else begin
			state <= next_state;
		end
	end

	assign latched_events = state.events;
	assign summary = |(state.events & event_mask); // see (R13) (R14) (R15)

endmodule : status_group

/* File: rtl/trigger_measure_status_groups.sv */
// Purpose: trigger-layer and measurement status register groups with command access
// Assumes: commands arrive decoded as one-cycle requests on cmd
// Notes: one response per command, one cycle after it is taken
// Summary of operation
// (R1) every group register is sixteen bits wide
// (R2) condition registers are read-only and follow their live signals
// (R3) trigger condition bit 1 follows the trigger layer flag
// (R4) measurement condition bit 9 follows the buffer full flag
// (R5) rising filter bit set: a 0 to 1 change sets the event bit
// (R6) falling filter bit set: a 1 to 0 change sets the event bit
// (R7) a position may watch rising, falling or both directions
// (R8) filters are writable and readable anytime; reading leaves them unchanged
// (R9) reset or preset loads rising filter all ones, falling all zeros
// (R10) event bits stay latched until a clearing action
// (R11) reading an event register clears all its bits except those with a fresh qualified edge in that cycle
// (R12) reset and clear-status also clear the event registers
// (R13) masked trigger events are ORed onto the waiting-for-trigger bit
// (R14) masked measurement events are ORed onto the measurement summary
// (R15) mask bit 0 blocks its event, mask bit 1 passes it
// (R16) only trigger mask bit 1 is settable
// (R17) masks clear only on reset or writing zero; reads leave them
// (R18) a qualified edge in the clear-on-read cycle stays set
// (R19) edges are found against last cycle's condition, latched at the clock
module trigger_measure_status_groups (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic trigger_layer_flag,
	input wire logic buffer_full_flag,
	input wire logic [15:0] measure_conditions,
	input wire status_groups_pkg::command_s cmd,
	output status_groups_pkg::response_s rsp,
	output logic [15:0] oper_condition_part,
	output logic waiting_for_trigger,
	output logic measure_summary
);

	localparam int W = status_groups_pkg::STATUS_WIDTH;

	if (W <= status_groups_pkg::BUFFER_FULL_BIT) begin : gen_width_check
		$error("status width too small for the buffer full bit");
	end

	// ==========================================================
	// state
	typedef struct packed {
		logic [status_groups_pkg::GROUP_COUNT-1:0][W-1:0] rise;
		logic [status_groups_pkg::GROUP_COUNT-1:0][W-1:0] fall;
		logic [status_groups_pkg::GROUP_COUNT-1:0][W-1:0] mask;
		status_groups_pkg::response_s rsp;
	} top_state_s;

	top_state_s state;
	top_state_s next_state;

	logic [status_groups_pkg::GROUP_COUNT-1:0][W-1:0] live;
	logic [status_groups_pkg::GROUP_COUNT-1:0][W-1:0] events;
	logic [status_groups_pkg::GROUP_COUNT-1:0] clear_events;
	logic [status_groups_pkg::GROUP_COUNT-1:0] summary;

	// ==========================================================
	// live condition assembly
	always_comb begin
		live = '0;
		live[status_groups_pkg::GROUP_TRIGGER][status_groups_pkg::TRIGGER_LAYER_BIT] =
			trigger_layer_flag; // see (R3) (R2)
		live[status_groups_pkg::GROUP_MEASURE] = measure_conditions; // see (R2)
		live[status_groups_pkg::GROUP_MEASURE][status_groups_pkg::BUFFER_FULL_BIT] =
			buffer_full_flag; // see (R4)
	end

	// ==========================================================
	// per-group event logic
	for (genvar g = 0; g < status_groups_pkg::GROUP_COUNT; g++) begin : gen_group
		status_group #(
			.WIDTH(W)
		) u_group (
			.sys_clk(sys_clk),
			.rst(rst),
			.live_state(live[g]),
			.rising_edge_filter(state.rise[g]),
			.falling_edge_filter(state.fall[g]),
			.event_mask(state.mask[g]),
			.clear_events(clear_events[g]),
			.latched_events(events[g]),
			.summary(summary[g])
		);
	end

	// ==========================================================
	// command decode
	always_comb begin
		next_state = state;
		next_state.rsp.valid = 1'b0;
		next_state.rsp.error = 1'b0;
		clear_events = '0;
		if (cmd.valid) begin
			case (cmd.op)
				status_groups_pkg::op_write: begin
					next_state.rsp.valid = 1'b1;
					case (cmd.sel)
						status_groups_pkg::reg_rise_filter: begin
							next_state.rise[cmd.group] = cmd.data; // see (R8) (R1)
						end
						status_groups_pkg::reg_fall_filter: begin
							next_state.fall[cmd.group] = cmd.data; // see (R8)
						end
						status_groups_pkg::reg_event_mask: begin
							if (cmd.group == status_groups_pkg::GROUP_TRIGGER) begin
								next_state.mask[cmd.group] = cmd.data
									& status_groups_pkg::TRIGGER_MASK_WRITABLE; // see (R16)
							end else begin
								next_state.mask[cmd.group] = cmd.data; // see (R17)
							end
						end
						default: begin
							// condition and event registers cannot be written
							next_state.rsp.error = 1'b1; // see (R2)
						end
					endcase
				end
				status_groups_pkg::op_read: begin
					next_state.rsp.valid = 1'b1;
					case (cmd.sel)
						status_groups_pkg::reg_live_state: begin
							next_state.rsp.data = live[cmd.group];
						end
						status_groups_pkg::reg_rise_filter: begin
							next_state.rsp.data = state.rise[cmd.group]; // see (R8)
						end
						status_groups_pkg::reg_fall_filter: begin
							next_state.rsp.data = state.fall[cmd.group]; // see (R8)
						end
						status_groups_pkg::reg_latched_events: begin
							next_state.rsp.data = events[cmd.group];
							clear_events[cmd.group] = 1'b1; // see (R11)
						end
						status_groups_pkg::reg_event_mask: begin
							next_state.rsp.data = state.mask[cmd.group]; // see (R17)
						end
						default: begin
							next_state.rsp.data = status_groups_pkg::READ_DATA_RESET;
							next_state.rsp.error = 1'b1;
						end
					endcase
				end
				status_groups_pkg::op_preset: begin
					next_state.rsp.valid = 1'b1;
					for (int i = 0; i < status_groups_pkg::GROUP_COUNT; i++) begin
						next_state.rise[i] = status_groups_pkg::RISE_FILTER_RESET; // see (R9)
						next_state.fall[i] = status_groups_pkg::FALL_FILTER_RESET; // see (R9)
					end
				end
				status_groups_pkg::op_clear_status: begin
					next_state.rsp.valid = 1'b1;
					clear_events = '1; // see (R12)
				end
				default: begin
					next_state.rsp.valid = 1'b1;
					next_state.rsp.error = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < status_groups_pkg::GROUP_COUNT; i++) begin
				state.rise[i] <= status_groups_pkg::RISE_FILTER_RESET; // see (R9)
				state.fall[i] <= status_groups_pkg::FALL_FILTER_RESET; // see (R9)
				state.mask[i] <= status_groups_pkg::EVENT_MASK_RESET; // see (R17)
			end
			state.rsp.valid <= 1'b0;
			state.rsp.error <= 1'b0;
			state.rsp.data <= status_groups_pkg::READ_DATA_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// outputs
	assign rsp = state.rsp;
	assign waiting_for_trigger = summary[status_groups_pkg::GROUP_TRIGGER]; // see (R13)
	assign measure_summary = summary[status_groups_pkg::GROUP_MEASURE]; // see (R14)

	always_comb begin
		oper_condition_part = '0;
		oper_condition_part[status_groups_pkg::OPER_WAIT_TRIGGER_BIT] =
			summary[status_groups_pkg::GROUP_TRIGGER]; // see (R13)
	end

endmodule : trigger_measure_status_groups

/* File: dv/status_groups_props.sv */
// Purpose: port checker for the status groups
// Assumes: one clock domain, reset rst
// Notes: bound to the top module
module status_groups_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic trigger_layer_flag,
	input wire logic buffer_full_flag,
	input wire logic [15:0] measure_conditions,
	input wire status_groups_pkg::command_s cmd,
	input wire status_groups_pkg::response_s rsp,
	input wire logic [15:0] oper_condition_part,
	input wire logic waiting_for_trigger,
	input wire logic measure_summary
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic live_rd;
	logic bad_wr;
	logic clr;
	assign live_rd = cmd.valid && cmd.op == status_groups_pkg::op_read
		&& cmd.sel == status_groups_pkg::reg_live_state;
	assign bad_wr = cmd.valid && cmd.op == status_groups_pkg::op_write && (cmd.sel
		== status_groups_pkg::reg_live_state || cmd.sel == status_groups_pkg::reg_latched_events);
	assign clr = cmd.valid && cmd.op == status_groups_pkg::op_clear_status;
	// ====
	// sequences and properties
	sequence s_trig_rd;
		live_rd && !cmd.group;
	endsequence
	sequence s_ok;
		rsp.valid && !rsp.error;
	endsequence
	property p_answer;
		cmd.valid |=> rsp.valid;
	endproperty
	property p_idle;
		!cmd.valid |=> !rsp.valid && !rsp.error;
	endproperty
	property p_trig_live;
		s_trig_rd |=> s_ok ##0 rsp.data == {14'h0000, $past(trigger_layer_flag), 1'b0};
	endproperty
	property p_meas_live;
		live_rd && cmd.group |=> rsp.data[9] == $past(buffer_full_flag);
	endproperty
	property p_bad_wr;
		bad_wr |=> rsp.valid && rsp.error;
	endproperty
	property p_oper;
		oper_condition_part == {10'h000, waiting_for_trigger, 5'h00};
	endproperty
	property p_hold;
		(waiting_for_trigger || measure_summary) && !cmd.valid
			|=> (waiting_for_trigger || measure_summary) [*1];
	endproperty
	property p_clear;
		clr && $stable(trigger_layer_flag) && $stable(buffer_full_flag)
			&& $stable(measure_conditions) |=> !waiting_for_trigger && !measure_summary;
	endproperty
	property p_quiet;
		!waiting_for_trigger && !cmd.valid && $stable(trigger_layer_flag)
			|=> !waiting_for_trigger;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer to command");
	a_idle: assert property (p_idle) else $error("answer without command");
	a_trig_live: assert property (p_trig_live) else $error("trigger live bad");
	a_meas_live: assert property (p_meas_live) else $error("buffer full bit bad");
	a_bad_wr: assert property (p_bad_wr) else $error("read-only write taken");
	a_oper: assert property (p_oper) else $error("operation bit 5 wrong");
	a_hold: assert property (p_hold) else $error("summary dropped");
	a_clear: assert property (p_clear) else $error("clear status missed");
	a_quiet: assert property (p_quiet) else $error("event without edge");
endmodule : status_groups_props
bind trigger_measure_status_groups status_groups_props props_i (.sys_clk, .rst,
	.trigger_layer_flag, .buffer_full_flag, .measure_conditions, .cmd, .rsp,
	.oper_condition_part, .waiting_for_trigger, .measure_summary);

/* File: dv/status_host.sv */
// Purpose: host model issuing status commands
// Assumes: answer comes one cycle after the taking edge
// Notes: idle data lines show the inverse of their last value
module status_host (
	input wire logic sys_clk,
	output status_groups_pkg::command_s cmd,
	input wire status_groups_pkg::response_s rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] rdata;
	logic err;
	logic got_valid;
	initial cmd = '0;
	// launch after one edge, taken at the next, answer picked up at the edge after that
	task automatic send(input status_groups_pkg::cmd_op_e op, input logic g,
		input status_groups_pkg::reg_sel_e sel, input logic [15:0] d);
		@(posedge sys_clk);
		cmd <= '{1'b1, op, g, sel, d};
		@(posedge sys_clk);
		cmd.valid <= 1'b0;
		cmd.data <= ~d;
		@(posedge sys_clk);
		rdata = rsp.data;
		err = rsp.error;
		got_valid = rsp.valid;
	endtask : send
endmodule : status_host

/* File: dv/testbench.sv */
// Purpose: self-checking bench for both status groups
// Assumes: host model issues every command
// Notes: random measurement traffic plus fixed trigger cases
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam status_groups_pkg::reg_sel_e sel_live = status_groups_pkg::reg_live_state;
	localparam status_groups_pkg::reg_sel_e sel_rise = status_groups_pkg::reg_rise_filter;
	localparam status_groups_pkg::reg_sel_e sel_fall = status_groups_pkg::reg_fall_filter;
	localparam status_groups_pkg::reg_sel_e sel_ev = status_groups_pkg::reg_latched_events;
	localparam status_groups_pkg::reg_sel_e sel_mask = status_groups_pkg::reg_event_mask;
	logic sys_clk;
	logic rst;
	logic trigger_layer_flag;
	logic buffer_full_flag;
	logic [15:0] measure_conditions;
	status_groups_pkg::command_s cmd;
	status_groups_pkg::response_s rsp;
	logic [15:0] oper_condition_part;
	logic waiting_for_trigger;
	logic measure_summary;
	int fail_count;
	int n_tests;
	int cycles;
	logic [15:0] rise;
	logic [15:0] fall;
	logic [15:0] mask;
	logic [15:0] prev;
	logic [15:0] cur;
	logic [15:0] ev;
	logic e;
	trigger_measure_status_groups dut (.sys_clk, .rst, .trigger_layer_flag, .buffer_full_flag,
		.measure_conditions, .cmd, .rsp, .oper_condition_part, .waiting_for_trigger,
		.measure_summary);
	status_host host (.sys_clk, .cmd, .rsp);
	// ====
	// expectation and access helpers
	function automatic logic [15:0] edges(logic [15:0] p, logic [15:0] c, logic [15:0] r,
		logic [15:0] f);
		return (~p & c & r) | (p & ~c & f);
	endfunction : edges
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic g, input status_groups_pkg::reg_sel_e s,
		input logic [15:0] exp);
		host.send(status_groups_pkg::op_read, g, s, 16'h0000);
		chk(host.rdata, exp);
		chk({15'h0000, host.got_valid}, 16'h0001);
	endtask : rd
	task automatic wr(input logic g, input status_groups_pkg::reg_sel_e s, input logic [15:0] d);
		host.send(status_groups_pkg::op_write, g, s, d);
	endtask : wr
	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			$display("ERROR t=%0t run did not finish in time", $time);
			results();
		end
	end
	// ====
	// main sequence
	initial begin
		rst = 1'b1;
		trigger_layer_flag = 1'b0;
		buffer_full_flag = 1'b0;
		measure_conditions = 16'h0000;
		void'($urandom(32'hC048));
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		for (int g = 0; g < 2; g++) begin
			rd(g[0], sel_rise, 16'hFFFF);
			rd(g[0], sel_fall, 16'h0000);
			rd(g[0], sel_mask, 16'h0000);
			rd(g[0], sel_ev, 16'h0000);
		end
		wr(1'b0, sel_mask, 16'hFFFF);
		rd(1'b0, sel_mask, 16'h0002);
		for (int m = 1; m < 4; m++) begin
			wr(1'b0, sel_rise, m[0] ? 16'h0002 : 16'h0000);
			wr(1'b0, sel_fall, m[1] ? 16'h0002 : 16'h0000);
			for (int k = 0; k < 2; k++) begin
				e = k == 0 ? m[0] : m[1];
				trigger_layer_flag <= ~trigger_layer_flag;
				repeat (3) @(posedge sys_clk);
				chk({14'h0000, waiting_for_trigger, oper_condition_part[5]},
					{14'h0000, e, e});
				rd(1'b0, sel_ev, {14'h0000, e, 1'b0});
				rd(1'b0, sel_ev, 16'h0000);
			end
		end
		wr(1'b0, sel_mask, 16'h0000);
		trigger_layer_flag <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk({15'h0000, waiting_for_trigger}, 16'h0000);
		rd(1'b0, sel_live, 16'h0002);
		host.send(status_groups_pkg::op_clear_status, 1'b0, sel_ev, 16'h0000);
		rd(1'b0, sel_ev, 16'h0000);
		fork
			rd(1'b0, sel_ev, 16'h0000);
			begin
				@(posedge sys_clk);
				trigger_layer_flag <= 1'b0;
			end
		join
		rd(1'b0, sel_ev, 16'h0002);
		wr(1'b0, sel_live, 16'hFFFF);
		chk({15'h0000, host.err}, 16'h0001);
		host.send(status_groups_pkg::op_preset, 1'b0, sel_ev, 16'h0000);
		rd(1'b0, sel_rise, 16'hFFFF);
		rd(1'b0, sel_fall, 16'h0000);
		prev = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			rise = 16'($urandom);
			fall = 16'($urandom);
			mask = 16'($urandom);
			wr(1'b1, sel_rise, rise);
			wr(1'b1, sel_fall, fall);
			wr(1'b1, sel_mask, mask);
			rd(1'b1, sel_fall, fall);
			rd(1'b1, sel_mask, mask);
			measure_conditions <= 16'($urandom);
			buffer_full_flag <= 1'($urandom);
			repeat (2) @(posedge sys_clk);
			cur = {measure_conditions[15:10], buffer_full_flag, measure_conditions[8:0]};
			ev = edges(prev, cur, rise, fall);
			chk({15'h0000, measure_summary}, {15'h0000, |(ev & mask)});
			rd(1'b1, sel_live, cur);
			rd(1'b1, sel_ev, ev);
			prev = cur;
		end
		results();
	end
endmodule : testbench
